// ### verilog/pfea_core.sv
// Purpose: instruction prefetch queue, bus sequencing, cycle accounting,
//          effective-address cost lookup, operand test and frame unlink
// Assumes: bus acknowledge and read data are synchronous to clk
// Notes:   one word per bus cycle; the bus never aborts a started cycle
// Behaviour
// - operand test sets N and Z from operand, clears V and C, keeps X
// - frame unlink copies address_reg to stack pointer, then pops long into it
// - each extension word consumed triggers one refill prefetch
// - last prefetch happens when operation word drops and next decode starts
// - branch keeps superfluous fetch; exception discards both queued words
// - program counter holds address of last fetched instruction word
// - bus cycle is four clocks minimum; each wait state adds one clock
// - reported clocks include instruction fetch and all operand accesses
// - every timing report carries read and write cycle counts
// - indirect and postincrement cost 4(1/0) word, 8(2/0) long
// - predecrement costs 6(1/0) word, 10(2/0) long
// - displacement indirect costs 8(2/0) word, 12(3/0) long
// - indexed indirect costs 10(2/0) word, 14(3/0) long
// - pc displacement costs 8(2/0) word, 12(3/0) long
// - pc indexed costs 10(2/0) word, 14(3/0) long
// - index_reg size never changes indexed timing
`include "pfea_params.svh"
`timescale 1ns/10ps
`default_nettype none

module pfea_core (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // memory bus
  output var  logic                 busReq,
  output var  logic [23:0]          busAddr,
  input  wire logic                 busAck,
  input  wire logic [15:0]          busRdata,
  // decoder side of the queue
  output var  logic                 wordValid,
  output var  logic [15:0]          wordData,
  output var  logic [23:0]          pcAddr,
  input  wire logic                 consumeExt,
  input  wire logic                 nextInstr,
  input  wire logic                 flush,
  input  wire logic                 flushExc,
  input  wire logic [23:0]          flushAddr,
  input  wire logic                 storeDone,
  // timing report
  output var  pfea_pkg::pfea_cost_t lastCost,
  // effective-address cost lookup
  input  wire logic                 eaReq,
  input  wire pfea_pkg::pfea_ea_mode_t eaMode,
  input  wire logic                 eaLong,
  output var  pfea_pkg::pfea_cost_t eaCost,
  // operation execution
  input  wire logic                 opStart,
  input  wire pfea_pkg::pfea_op_t   opSel,
  input  wire pfea_pkg::pfea_size_t opSize,
  input  wire logic [31:0]          operand,
  input  wire logic [31:0]          addrRegIn,
  input  wire pfea_pkg::pfea_flags_t flagsIn,
  output var  pfea_pkg::pfea_flags_t flagsOut,
  output var  logic [31:0]          stackPtr,
  output var  logic [31:0]          addrRegOut,
  output var  logic                 opBusy,
  output var  logic                 opDone
);

  typedef enum logic [1:0] {BS_IDLE = 2'b01, BS_CYC = 2'b10} pfea_bus_st_t;
  typedef enum logic [2:0] {
    EX_IDLE = 3'b001, EX_HI = 3'b010, EX_LO = 3'b100
  } pfea_ex_st_t;

  pfea_bus_st_t busSt_r;
  pfea_ex_st_t  exSt_r;
  logic [3:0]   busCnt_r;
  logic         busIsOp_r;
  logic         discard_r;
  logic [1:0]   fetchPend_r;
  logic [1:0]   qCnt_r;
  logic [15:0]  q1_r;
  logic [23:0]  fetchAddr_r;
  logic [31:0]  popAddr_r;
  logic [15:0]  popHi_r;
  logic [7:0]   instrClk_r;
  logic [3:0]   instrRd_r;
  logic [3:0]   instrWr_r;
  logic         busFin;
  logic         opWant;
  logic         fetchStart;
  logic         opBusStart;
  logic         pop;
  logic         fetchFin;
  logic [1:0]   qCnt_nxt;

  // a cycle ends only after the minimum length and the acknowledge
  assign busFin = busSt_r == BS_CYC && busCnt_r >= `PFEA_BUS_CYC_CLKS - 4'h1
                  && busAck;
  assign opWant     = exSt_r != EX_IDLE;
  // operand reads win over prefetch so the unlink is not starved
  assign opBusStart = busSt_r == BS_IDLE && opWant;
  assign fetchStart = busSt_r == BS_IDLE && !opWant && !flush
                      && fetchPend_r != 2'h0;
  assign pop        = (consumeExt || nextInstr) && qCnt_r != 2'h0;
  assign fetchFin   = busFin && !busIsOp_r && !discard_r && !flush;

  always_comb
  begin
    qCnt_nxt = qCnt_r - 2'(pop) + 2'(fetchFin);
    if (flush)
      qCnt_nxt = 2'h0;
  end

  // bus sequencer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busSt_r   <= BS_IDLE;
      busReq    <= 1'b0;
      busAddr   <= `PFEA_RESET_ADDR;
      busCnt_r  <= 4'h0;
      busIsOp_r <= 1'b0;
    end
    else
    begin
      unique case (busSt_r)
        BS_IDLE:
        begin
          busCnt_r <= 4'h0;
          if (opBusStart || fetchStart)
          begin
            busSt_r   <= BS_CYC;
            busReq    <= 1'b1;
            busIsOp_r <= opBusStart;
            busAddr   <= opBusStart ? popAddr_r[23:0] : fetchAddr_r;
          end
        end
        BS_CYC:
        begin
          // saturate so long wait states cannot wrap below the minimum
          if (busCnt_r < `PFEA_BUS_CYC_CLKS - 4'h1)
            busCnt_r <= busCnt_r + 4'h1;
          if (busFin)
          begin
            busSt_r <= BS_IDLE;
            busReq  <= 1'b0;
          end
        end
      endcase
    end
  end

  // prefetch bookkeeping
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fetchPend_r <= `PFEA_QUEUE_DEPTH;
      fetchAddr_r <= `PFEA_RESET_ADDR;
      discard_r   <= 1'b0;
    end
    else if (flush)
    begin
      // both queued words are dropped and fetched again from the new stream
      fetchPend_r <= `PFEA_QUEUE_DEPTH;
      fetchAddr_r <= flushAddr;
      discard_r   <= busSt_r == BS_CYC && !busIsOp_r && !busFin;
    end
    else
    begin
      fetchPend_r <= fetchPend_r + 2'(pop) - 2'(fetchStart);
      if (fetchStart)
        fetchAddr_r <= fetchAddr_r + `PFEA_WORD_STEP;
      if (busFin && !busIsOp_r)
        discard_r <= 1'b0;
    end
  end

  // two-word queue; wordData is the head
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      qCnt_r    <= 2'h0;
      wordValid <= 1'b0;
      wordData  <= 16'h0000;
      q1_r      <= 16'h0000;
      pcAddr    <= `PFEA_RESET_ADDR;
    end
    else
    begin
      qCnt_r    <= qCnt_nxt;
      wordValid <= qCnt_nxt != 2'h0;
      if (fetchFin)
        pcAddr <= busAddr;
      if (pop && qCnt_r == 2'h2)
      begin
        wordData <= q1_r;
        if (fetchFin)
          q1_r <= busRdata;
      end
      else if (fetchFin && (qCnt_r == 2'h0 || (pop && qCnt_r == 2'h1)))
        wordData <= busRdata;
      else if (fetchFin)
        q1_r <= busRdata;
    end
  end

  // per-instruction clock and bus cycle accounting
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      instrClk_r <= 8'h00;
      instrRd_r  <= 4'h0;
      instrWr_r  <= 4'h0;
      lastCost   <= '0;
    end
    else if (nextInstr)
    begin
      lastCost.clocks <= instrClk_r + 8'h01;
      lastCost.reads  <= instrRd_r + 4'(busFin);
      lastCost.writes <= instrWr_r + 4'(storeDone);
      instrClk_r      <= 8'h00;
      instrRd_r       <= 4'h0;
      instrWr_r       <= 4'h0;
    end
    else
    begin
      // every clock counts, so wait states lengthen the figure one for one
      instrClk_r <= instrClk_r + 8'h01;
      instrRd_r  <= instrRd_r + 4'(busFin);
      instrWr_r  <= instrWr_r + 4'(storeDone);
    end
  end

  // effective-address cost; index_reg size is deliberately not an input
  always_ff @(posedge clk)
  begin
    if (rst)
      eaCost <= '0;
    else if (eaReq)
    begin
      eaCost.writes <= 4'h0;
      unique case (eaMode)
        pfea_pkg::EA_DREG, pfea_pkg::EA_AREG:
        begin
          eaCost.clocks <= 8'h00;
          eaCost.reads  <= 4'h0;
        end
        pfea_pkg::EA_IND, pfea_pkg::EA_POSTINC, pfea_pkg::EA_IMM:
        begin
          eaCost.clocks <= eaLong ? `PFEA_CLK_IND_L : `PFEA_CLK_IND_W;
          eaCost.reads  <= eaLong ? `PFEA_RD_TWO : `PFEA_RD_ONE;
        end
        pfea_pkg::EA_PREDEC:
        begin
          eaCost.clocks <= eaLong ? `PFEA_CLK_PREDEC_L : `PFEA_CLK_PREDEC_W;
          eaCost.reads  <= eaLong ? `PFEA_RD_TWO : `PFEA_RD_ONE;
        end
        pfea_pkg::EA_DISP, pfea_pkg::EA_PCDISP, pfea_pkg::EA_ABSW:
        begin
          eaCost.clocks <= eaLong ? `PFEA_CLK_DISP_L : `PFEA_CLK_DISP_W;
          eaCost.reads  <= eaLong ? `PFEA_RD_THREE : `PFEA_RD_TWO;
        end
        pfea_pkg::EA_INDEX, pfea_pkg::EA_PCINDEX:
        begin
          eaCost.clocks <= eaLong ? `PFEA_CLK_INDEX_L : `PFEA_CLK_INDEX_W;
          eaCost.reads  <= eaLong ? `PFEA_RD_THREE : `PFEA_RD_TWO;
        end
        pfea_pkg::EA_ABSL:
        begin
          eaCost.clocks <= eaLong ? `PFEA_CLK_ABSL_L : `PFEA_CLK_ABSL_W;
          eaCost.reads  <= eaLong ? `PFEA_RD_FOUR : `PFEA_RD_THREE;
        end
        default:
        begin
          eaCost.clocks <= 8'h00;
          eaCost.reads  <= 4'h0;
        end
      endcase
    end
  end

  // operand test and frame unlink
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      exSt_r     <= EX_IDLE;
      flagsOut   <= '0;
      stackPtr   <= 32'h0000_0000;
      addrRegOut <= 32'h0000_0000;
      popAddr_r  <= 32'h0000_0000;
      popHi_r    <= 16'h0000;
      opBusy     <= 1'b0;
      opDone     <= 1'b0;
    end
    else
    begin
      opDone <= 1'b0;
      unique case (exSt_r)
        EX_IDLE:
        begin
          if (opStart && opSel == pfea_pkg::OP_TST)
          begin
            flagsOut.x <= flagsIn.x;
            flagsOut.n <= opSize == pfea_pkg::SZ_BYTE ? operand[7]
                        : opSize == pfea_pkg::SZ_WORD ? operand[15]
                        : operand[31];
            flagsOut.z <= opSize == pfea_pkg::SZ_BYTE ? operand[7:0] == 8'h00
                        : opSize == pfea_pkg::SZ_WORD
                          ? operand[15:0] == 16'h0000
                        : operand == 32'h0000_0000;
            flagsOut.v <= 1'b0;
            flagsOut.c <= 1'b0;
            opDone     <= 1'b1;
          end
          else if (opStart && opSel == pfea_pkg::OP_FRAME_UNLINK_OP)
          begin
            stackPtr  <= addrRegIn;
            popAddr_r <= addrRegIn;
            opBusy    <= 1'b1;
            exSt_r    <= EX_HI;
          end
        end
        EX_HI:
          if (busFin && busIsOp_r)
          begin
            popHi_r   <= busRdata;
            popAddr_r <= popAddr_r + 32'h0000_0002;
            exSt_r    <= EX_LO;
          end
        EX_LO:
          if (busFin && busIsOp_r)
          begin
            addrRegOut <= {popHi_r, busRdata};
            stackPtr   <= popAddr_r + 32'h0000_0002;
            opBusy     <= 1'b0;
            opDone     <= 1'b1;
            exSt_r     <= EX_IDLE;
          end
      endcase
    end
  end

  // checks
  sequence s_frame_unlink_op_go;
    opStart && opSel == pfea_pkg::OP_FRAME_UNLINK_OP && exSt_r == EX_IDLE;
  endsequence

  property p_tst_flags;
    @(posedge clk) disable iff (rst)
    opStart && opSel == pfea_pkg::OP_TST && exSt_r == EX_IDLE && opSize
      == pfea_pkg::SZ_LONG |=> flagsOut.n == $past(operand[31]) && !flagsOut.v
      && !flagsOut.c && flagsOut.x == $past(flagsIn.x) && opDone;
  endproperty
  a_tst_flags: assert property (p_tst_flags) else $error("tst flags wrong");

  property p_frame_unlink_op_sp;
    @(posedge clk) disable iff (rst)
    s_frame_unlink_op_go |=> stackPtr == $past(addrRegIn) && opBusy;
  endproperty
  a_frame_unlink_op_sp: assert property (p_frame_unlink_op_sp) else $error("unlink sp wrong");

  property p_pop_fetch;
    @(posedge clk) disable iff (rst)
    pop && !flush && !fetchStart |=> fetchPend_r == $past(fetchPend_r) + 2'h1;
  endproperty
  a_pop_fetch: assert property (p_pop_fetch) else $error("no refill");

  property p_flush_drop;
    @(posedge clk) disable iff (rst)
    flush |=> qCnt_r == 2'h0 && !wordValid && fetchPend_r == 2'h2;
  endproperty
  a_flush_drop: assert property (p_flush_drop) else $error("flush kept words");

  property p_pc_last;
    @(posedge clk) disable iff (rst)
    fetchFin |=> pcAddr == $past(busAddr);
  endproperty
  a_pc_last: assert property (p_pc_last) else $error("pc not last fetch");

  sequence s_bus_open;
    $rose(busReq);
  endsequence

  property p_bus_min;
    @(posedge clk) disable iff (rst)
    s_bus_open |-> busReq [*4];
  endproperty
  a_bus_min: assert property (p_bus_min) else $error("bus cycle short");

  property p_clk_count;
    @(posedge clk) disable iff (rst)
    nextInstr |=> lastCost.clocks == $past(instrClk_r) + 8'h01
      && instrClk_r == 8'h00 ##1 (instrClk_r == 8'h01 || $past(nextInstr));
  endproperty
  a_clk_count: assert property (p_clk_count) else $error("clock count");

  property p_ea_ind;
    @(posedge clk) disable iff (rst)
    eaReq && eaMode == pfea_pkg::EA_INDEX |=> eaCost.clocks
      == ($past(eaLong) ? 8'h0e : 8'h0a) && eaCost.reads
      == ($past(eaLong) ? 4'h3 : 4'h2);
  endproperty
  a_ea_ind: assert property (p_ea_ind) else $error("index cost");

  property p_ea_reg;
    @(posedge clk) disable iff (rst)
    eaReq && (eaMode == pfea_pkg::EA_DREG || eaMode == pfea_pkg::EA_AREG)
      |=> eaCost == '0;
  endproperty
  a_ea_reg: assert property (p_ea_reg) else $error("direct cost");

endmodule

`default_nettype wire

// ### verilog/pfea_params.svh
// Purpose: constants for the prefetch and effective-address timing block
// Assumes: 100 MHz clock, one word per bus cycle, 24-bit byte addresses
// Notes:   cost figures are clocks and read cycles per addressing mode
`ifndef PFEA_PARAMS_SVH
`define PFEA_PARAMS_SVH

`define PFEA_BUS_CYC_CLKS   4'h4
`define PFEA_WORD_STEP      24'h00_0002
`define PFEA_QUEUE_DEPTH    2'h2
`define PFEA_RESET_ADDR     24'h00_0000

`define PFEA_CLK_IND_W      8'h04
`define PFEA_CLK_IND_L      8'h08
`define PFEA_CLK_PREDEC_W   8'h06
`define PFEA_CLK_PREDEC_L   8'h0a
`define PFEA_CLK_DISP_W     8'h08
`define PFEA_CLK_DISP_L     8'h0c
`define PFEA_CLK_INDEX_W    8'h0a
`define PFEA_CLK_INDEX_L    8'h0e
`define PFEA_CLK_ABSL_W     8'h0c
`define PFEA_CLK_ABSL_L     8'h10
`define PFEA_RD_ONE         4'h1
`define PFEA_RD_TWO         4'h2
`define PFEA_RD_THREE       4'h3
`define PFEA_RD_FOUR        4'h4

`endif

// ### verilog/pfea_pkg.sv
// Purpose: shared types of the prefetch and effective-address timing block
// Assumes: nothing beyond the parameter header
// Notes:   costs travel as one packed struct
package pfea_pkg;

  typedef enum logic [3:0] {
    EA_DREG, EA_AREG, EA_IND, EA_POSTINC, EA_PREDEC, EA_DISP, EA_INDEX,
    EA_ABSW, EA_ABSL, EA_PCDISP, EA_PCINDEX, EA_IMM
  } pfea_ea_mode_t;

  typedef enum logic [1:0] {OP_NONE, OP_TST, OP_FRAME_UNLINK_OP} pfea_op_t;

  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} pfea_size_t;

  typedef struct packed {
    logic [7:0] clocks;
    logic [3:0] reads;
    logic [3:0] writes;
  } pfea_cost_t;

  typedef struct packed {
    logic x;
    logic n;
    logic z;
    logic v;
    logic c;
  } pfea_flags_t;

endpackage

// ### verif/pfea_mem_model.sv
// Purpose: memory on the processor bus, answering prefetch and operand reads
// Assumes: acknowledge is a one-cycle pulse once the cycle is long enough
// Notes:   the data line shows the inverted last value outside acknowledge,
//          so a sample one clock late reads inverted data; two clocks late it is good again
`timescale 1ns/10ps
`default_nettype none

module pfea_mem_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // bus
  input  wire logic        busReq,
  input  wire logic [23:0] busAddr,
  output var  logic        busAck,
  output var  logic [15:0] busRdata,
  // control and status
  input  wire logic [3:0]  waitStates,
  output var  logic [15:0] readCount,
  output var  logic [7:0]  cycLen
);
  logic [7:0] cnt;
  logic       ackNxt;

  assign ackNxt = busReq && !busAck
                  && (cnt + 8'h01 >= 8'h03 + {4'h0, waitStates});

  // four clocks per cycle, each wait state one more
  always_ff @(posedge clk)
  begin
    if (rst || !busReq)
    begin
      cnt    <= 8'h00;
      busAck <= 1'b0;
    end
    else
    begin
      cnt    <= cnt + 8'h01;
      busAck <= ackNxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      busRdata <= 16'h0000;
    else if (ackNxt)
      busRdata <= busAddr[16:1] ^ 16'h5a3c;
    else
      busRdata <= ~busRdata;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      readCount <= 16'h0000;
      cycLen    <= 8'h00;
    end
    else if (busReq && busAck)
    begin
      readCount <= readCount + 16'h0001;
      cycLen    <= cnt + 8'h01;
    end
  end
endmodule

`default_nettype wire

// ### verif/tb_prefetch_and_ea_timing.sv
// Purpose: self-checking bench for the prefetch and address timing core
// Assumes: inputs change at the falling edge
// Notes:   memory data is a fixed function of the address
`timescale 1ns/10ps
`default_nettype none

module tb_prefetch_and_ea_timing;
  logic clk, rst, busReq, busAck, wordValid, consumeExt, nextInstr;
  logic flush, flushExc, storeDone, eaReq, eaLong, opStart, opBusy, opDone;
  logic [23:0] busAddr, pcAddr, flushAddr;
  logic [15:0] busRdata, wordData, reads;
  logic [31:0] operand, addrRegIn, stackPtr, addrRegOut;
  logic [7:0] cycLen;
  logic [3:0] waitStates;
  pfea_pkg::pfea_cost_t lastCost, eaCost;
  pfea_pkg::pfea_ea_mode_t eaMode;
  pfea_pkg::pfea_op_t opSel;
  pfea_pkg::pfea_size_t opSize;
  pfea_pkg::pfea_flags_t flagsIn, flagsOut;
  int num_errors = 0, checked = 0, cyc = 0;

  pfea_core i_pfea_core (.clk(clk), .rst(rst), .busReq(busReq),
    .busAddr(busAddr), .busAck(busAck), .busRdata(busRdata),
    .wordValid(wordValid), .wordData(wordData), .pcAddr(pcAddr),
    .consumeExt(consumeExt), .nextInstr(nextInstr), .flush(flush),
    .flushExc(flushExc), .flushAddr(flushAddr), .storeDone(storeDone),
    .lastCost(lastCost), .eaReq(eaReq), .eaMode(eaMode), .eaLong(eaLong),
    .eaCost(eaCost), .opStart(opStart), .opSel(opSel), .opSize(opSize),
    .operand(operand), .addrRegIn(addrRegIn), .flagsIn(flagsIn),
    .flagsOut(flagsOut), .stackPtr(stackPtr), .addrRegOut(addrRegOut),
    .opBusy(opBusy), .opDone(opDone));

  pfea_mem_model i_pfea_mem_model (.clk(clk), .rst(rst), .busReq(busReq),
    .busAddr(busAddr), .busAck(busAck), .busRdata(busRdata),
    .waitStates(waitStates), .readCount(reads), .cycLen(cycLen));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) cyc++;

  function automatic logic [15:0] mw(input logic [23:0] a);
    return a[16:1] ^ 16'h5a3c;
  endfunction

  task automatic check(input bit ok, input string msg);
    checked++;
    if (!ok)
    begin
      num_errors++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  // bus quiet for ten cycles means the queue has settled
  task automatic wait_quiet;
    int q, n;
    q = 0;
    for (n = 0; n < 400 && q < 10; n++)
    begin
      step(1);
      q = busReq ? 0 : q + 1;
    end
    if (q < 10)
    begin
      check(0, "bus never settled");
      finish_test();
    end
  endtask

  task automatic t_fill;
    wait_quiet();
    check(wordValid === 1'b1 && wordData === mw(24'h0), "first word");
    check(pcAddr === 24'h00_0002, "pc after fill");
    $display("fill done");
  endtask

  // slow memory; one extension word and one store inside the instruction
  task automatic t_consume;
    logic [15:0] r0;
    int c0;
    waitStates = 4'h2;
    nextInstr = 1'b1;
    c0 = cyc;
    step(1);
    nextInstr = 1'b0;
    wait_quiet();
    r0 = reads;
    consumeExt = 1'b1;
    storeDone = 1'b1;
    step(1);
    consumeExt = 1'b0;
    storeDone = 1'b0;
    wait_quiet();
    check(reads === r0 + 16'h0001, "one refill per word");
    check(cycLen === 8'h06, "wait states lengthen cycle");
    check(wordData === mw(24'h4) && pcAddr === 24'h00_0006, "queue");
    nextInstr = 1'b1;
    c0 = cyc - c0;
    step(1);
    nextInstr = 1'b0;
    check(lastCost.reads === 4'(reads - r0 + 16'h0001), "reads");
    check(lastCost.writes === 4'h1, "writes");
    check(lastCost.clocks === 8'(c0), "clocks");
    wait_quiet();
    check(reads === r0 + 16'h0002, "prefetch at next decode");
    waitStates = 4'h0;
    $display("consume done");
  endtask

  task automatic t_ea;
    logic [7:0] ck [12] = '{0, 0, 4, 4, 6, 8, 10, 8, 12, 8, 10, 4};
    logic [3:0] rd [12] = '{0, 0, 1, 1, 1, 2, 2, 2, 3, 2, 2, 1};
    int i, l;
    // request held high so back-to-back lookups never re-drive it
    eaReq = 1'b1;
    for (i = 0; i < 24; i++)
    begin
      l = i % 2;
      eaMode = pfea_pkg::pfea_ea_mode_t'(4'(i / 2));
      eaLong = l[0];
      step(1);
      if (i > 3)
        check(eaCost === {ck[i/2] + 8'(4 * l), rd[i/2] + 4'(l), 4'h0},
          "cost");
      else
        check(eaCost === 16'h0000, "register mode cost");
    end
    eaMode = pfea_pkg::EA_ABSL;
    eaLong = 1'b1;
    step(1);
    check(eaCost === 16'h1040, "absolute long");
    eaMode = pfea_pkg::EA_PCINDEX;
    eaLong = 1'b0;
    step(1);
    eaReq = 1'b0;
    check(eaCost === 16'h0a20, "pc index word");
    $display("address costs done");
  endtask

  task automatic t_tst;
    logic [31:0] v [4] = '{32'h8000_0000, 32'h0, 32'h0000_0080, 32'h0001_0000};
    pfea_pkg::pfea_size_t s [4] = '{pfea_pkg::SZ_LONG, pfea_pkg::SZ_LONG,
      pfea_pkg::SZ_BYTE, pfea_pkg::SZ_WORD};
    logic [1:0] nz [4] = '{2'b10, 2'b01, 2'b10, 2'b01};
    int i;
    opSel = pfea_pkg::OP_TST;
    opStart = 1'b1;
    for (i = 0; i < 4; i++)
    begin
      operand = v[i];
      opSize = s[i];
      flagsIn = (i % 2) ? 5'h1f : 5'h00;
      step(1);
      check(opDone === 1'b1 && flagsOut === {flagsIn.x, nz[i], 2'b00},
        "test flags");
    end
    opStart = 1'b0;
    $display("test op done");
  endtask

  task automatic t_frame_unlink_op;
    int n;
    addrRegIn = 32'h0000_0100;
    opSel = pfea_pkg::OP_FRAME_UNLINK_OP;
    opStart = 1'b1;
    step(1);
    opStart = 1'b0;
    check(stackPtr === 32'h0000_0100 && opBusy === 1'b1, "sp copy");
    for (n = 0; n < 100 && opDone !== 1'b1; n++)
      step(1);
    if (opDone !== 1'b1)
    begin
      check(0, "unlink never ended");
      finish_test();
    end
    check(addrRegOut === {mw(24'h100), mw(24'h102)}, "pop");
    check(stackPtr === 32'h0000_0104, "sp after pop");
    wait_quiet();
    $display("unlink done");
  endtask

  // exception flush on a full queue, branch flush with a fetch in flight
  task automatic t_flush;
    int k;
    logic [15:0] r0;
    for (k = 0; k < 2; k++)
    begin
      r0 = reads;
      if (k == 1)
      begin
        consumeExt = 1'b1;
        step(1);
        consumeExt = 1'b0;
        step(2);
      end
      flushExc = (k == 0);
      flushAddr = 24'h00_0200 + 24'(k * 256);
      flush = 1'b1;
      step(1);
      flush = 1'b0;
      wait_quiet();
      check(wordData === mw(flushAddr), "refetch target");
      check(pcAddr === flushAddr + 24'h2, "pc after flush");
      check(reads === r0 + 16'(2 + k), "superfluous fetch");
    end
    $display("flush done");
  endtask

  initial
  begin
    rst = 1'b1;
    {consumeExt, nextInstr, flush, flushExc, storeDone, eaReq, eaLong} = '0;
    {opStart, operand, addrRegIn, flushAddr} = '0;
    eaMode = pfea_pkg::EA_DREG;
    opSel = pfea_pkg::OP_NONE;
    opSize = pfea_pkg::SZ_WORD;
    flagsIn = '0;
    waitStates = 4'h0;
    step(8);
    check(busReq === 1'b0 && wordValid === 1'b0, "reset state");
    rst = 1'b0;
    t_fill();
    t_ea();
    t_tst();
    t_frame_unlink_op();
    t_consume();
    t_flush();
    finish_test();
  end
endmodule

`default_nettype wire
